// >>> rtl/ctl_store_pkg.sv
// Purpose: Constants and types shared by the control and system register store unit.
// Assumes: 16-bit instruction words, 32-bit registers, one core clock.
// Notes: Function
// Function
// - Register-destination stores of global base, vector base and saved status copy into Rn in one cycle, flag untouched.
// - Register-destination stores of saved pc, saved stack and debug base copy into Rn in one cycle, flag untouched.
// - Banked stores to Rn take the bank index from opcode bits 6 to 4 and copy in one cycle.
// - Bank select bit 1 reads the bank-0 copy, 0 reads the bank-1 copy.
// - Push of global base writes the longword at Rn minus 4, then sets Rn to that address once the write is accepted.
// - Push of vector base, saved status and saved pc decrement Rn by 4 and write the longword there.
// - Push of saved stack and debug base subtract 4 from Rn and store the longword there.
// - Banked push forms take index from bits 6 to 4, decrement Rn by 4 and write that register.
// - All control stores and pushes are privileged except the two global base forms.
// - A privileged control store in user mode raises general illegal instruction instead.
// - A control store in a delay slot can raise slot illegal instruction.
// - Push forms check the write for translation multiple hit, miss and protection violation.
// - Push forms also raise initial page write or data address error on those conditions.
// - System stores of mac high, mac low and return register to Rn take one cycle, flag untouched.
// - System push forms decrement Rn by 4 and write the register longword there.
// - Register subtract writes Rn minus Rm into Rn in one cycle, flag untouched.

package ctl_store_pkg;

	localparam int DATA_W = 32;
	localparam logic [31:0] PUSH_STEP = 32'h0000_0004;
	localparam logic [31:0] PC_STEP = 32'h0000_0002;
	localparam logic [31:0] RESET_PC = 32'hA000_0000;

	// Source selectors
	typedef enum logic [3:0] {
		SRC_NONE = 4'h0,
		SRC_GBR_SEL = 4'h1,
		SRC_VEC = 4'h2,
		SRC_SST = 4'h3,
		SRC_SPC_SEL = 4'h4,
		SRC_SSK = 4'h5,
		SRC_DBG = 4'h6,
		SRC_BANK = 4'h7,
		SRC_MHI = 4'h8,
		SRC_MLO = 4'h9,
		SRC_RET = 4'hA,
		SRC_SUB = 4'hB
	} src_sel_t;

	// Exception codes
	typedef enum logic [2:0] {
		EXC_NONE = 3'h0,
		EXC_ILLEGAL = 3'h1,
		EXC_SLOT_ILLEGAL = 3'h2,
		EXC_TLB_MULTI = 3'h3,
		EXC_TLB_MISS = 3'h4,
		EXC_TLB_PROT = 3'h5,
		EXC_PAGE_WRITE = 3'h6,
		EXC_ADDR_ERR = 3'h7
	} exc_code_t;

	// Sequencer states, gray along issue, wait, done
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_DONE = 2'b11
	} seq_state_t;

endpackage : ctl_store_pkg

// >>> rtl/ctl_store_decode.sv
// Purpose: Combinational decoder for control, system store and subtract opcodes.
// Assumes: Opcode is stable while decoded.
// Notes: Pure logic, no state.
`timescale 1ns/1ps
module ctl_store_decode
	import ctl_store_pkg::*;
(
	input wire logic [15:0] opcode_in,
	output logic valid_out,
	output logic is_push_out,
	output logic is_control_out,
	output logic privileged_out,
	output src_sel_t src_out,
	output logic [2:0] bank_idx_out
);
	logic [3:0] hi;
	logic [7:0] lo;
	assign hi = opcode_in[15:12];
	assign lo = opcode_in[7:0];
	assign bank_idx_out = opcode_in[6:4];

	always_comb begin
		valid_out = 1'b0;
		is_push_out = 1'b0;
		is_control_out = 1'b0;
		src_out = SRC_NONE;
		if (hi == 4'h0) begin
			valid_out = 1'b1;
			is_control_out = 1'b1;
			case (lo)
				8'h12: src_out = SRC_GBR_SEL;
				8'h22: src_out = SRC_VEC;
				8'h32: src_out = SRC_SST;
				8'h42: src_out = SRC_SPC_SEL;
				8'h3A: src_out = SRC_SSK;
				8'hFA: src_out = SRC_DBG;
				8'h0A: begin
					src_out = SRC_MHI;
					is_control_out = 1'b0;
				end
				8'h1A: begin
					src_out = SRC_MLO;
					is_control_out = 1'b0;
				end
				8'h2A: begin
					src_out = SRC_RET;
					is_control_out = 1'b0;
				end
				default: begin
					if (lo[7] && lo[3:0] == 4'h2) begin
						src_out = SRC_BANK;
					end else begin
						valid_out = 1'b0;
						is_control_out = 1'b0;
					end
				end
			endcase
		end else if (hi == 4'h4) begin
			valid_out = 1'b1;
			is_push_out = 1'b1;
			is_control_out = 1'b1;
			case (lo)
				8'h13: src_out = SRC_GBR_SEL;
				8'h23: src_out = SRC_VEC;
				8'h33: src_out = SRC_SST;
				8'h43: src_out = SRC_SPC_SEL;
				8'h32: src_out = SRC_SSK;
				8'hF2: src_out = SRC_DBG;
				8'h02: begin
					src_out = SRC_MHI;
					is_control_out = 1'b0;
				end
				8'h12: begin
					src_out = SRC_MLO;
					is_control_out = 1'b0;
				end
				8'h22: begin
					src_out = SRC_RET;
					is_control_out = 1'b0;
				end
				default: begin
					if (lo[7] && lo[3:0] == 4'h3) begin
						src_out = SRC_BANK;
					end else begin
						valid_out = 1'b0;
						is_push_out = 1'b0;
						is_control_out = 1'b0;
					end
				end
			endcase
		end else if (hi == 4'h3 && opcode_in[3:0] == 4'h8) begin
			valid_out = 1'b1;
			src_out = SRC_SUB;
		end
	end

	// Control stores privileged except the global base forms
	assign privileged_out = is_control_out && (src_out != SRC_GBR_SEL);

endmodule : ctl_store_decode

// >>> rtl/ctl_store_mem_check.sv
// Purpose: Classifies the answer of a longword push write into an exception code.
// Assumes: Fault inputs are valid with the response strobe.
// Notes: Fixed priority, misalignment first.
`timescale 1ns/1ps
module ctl_store_mem_check
	import ctl_store_pkg::*;
(
	input wire logic [31:0] addr_in,
	input wire logic tlb_multi_hit_in,
	input wire logic tlb_miss_in,
	input wire logic tlb_prot_in,
	input wire logic page_first_write_in,
	output exc_code_t exc_out
);
	always_comb begin
		if (addr_in[1:0] != 2'b00) begin
			exc_out = EXC_ADDR_ERR;
		end else if (tlb_multi_hit_in) begin
			exc_out = EXC_TLB_MULTI;
		end else if (tlb_miss_in) begin
			exc_out = EXC_TLB_MISS;
		end else if (tlb_prot_in) begin
			exc_out = EXC_TLB_PROT;
		end else if (page_first_write_in) begin
			exc_out = EXC_PAGE_WRITE;
		end else begin
			exc_out = EXC_NONE;
		end
	end
endmodule : ctl_store_mem_check

// >>> rtl/control_store_sub_exec.sv
// Purpose: Executes control and system register stores, their pushes, and register subtract.
// Assumes: One instruction at a time, presented with issue_in; memory answers with mem_ack_in.
// Notes: General registers live here, control and system registers come in as ports; a memory push waits for its answer.
`timescale 1ns/1ps
module control_store_sub_exec
	import ctl_store_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic reset_in,
	input wire logic issue_in,
	input wire logic [15:0] opcode_in,
	input wire logic in_delay_slot_in,
	input wire logic user_mode_in,
	input wire logic bank_select_bit_in,
	input wire logic [31:0] global_base_reg_in,
	input wire logic [31:0] vector_base_reg_in,
	input wire logic [31:0] saved_status_reg_in,
	input wire logic [31:0] saved_pc_reg_in,
	input wire logic [31:0] saved_stack_reg_in,
	input wire logic [31:0] debug_base_reg_in,
	input wire logic [31:0] mac_high_half_in,
	input wire logic [31:0] mac_low_half_in,
	input wire logic [31:0] procedure_return_reg_in,
	input wire logic [255:0] banked_gpr_bank0_in,
	input wire logic [255:0] banked_gpr_bank1_in,
	input wire logic gpr_load_in,
	input wire logic [3:0] gpr_load_idx_in,
	input wire logic [31:0] gpr_load_data_in,
	input wire logic mem_ack_in,
	input wire logic tlb_multi_hit_in,
	input wire logic tlb_miss_in,
	input wire logic tlb_prot_in,
	input wire logic page_first_write_in,
	output logic busy_out,
	output logic done_out,
	output logic exc_valid_out,
	output exc_code_t exc_code_out,
	output logic [31:0] pc_out,
	output logic mem_write_out,
	output logic [31:0] mem_addr_out,
	output logic [31:0] mem_data_out,
	output logic [3:0] rd_idx_out,
	output logic [31:0] rd_data_out
);
	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	logic dec_valid;
	logic dec_push;
	logic dec_ctl;
	logic dec_priv;
	src_sel_t dec_src;
	logic [2:0] dec_bank;
	exc_code_t mem_exc;

	ctl_store_decode u_decode (
		.opcode_in(opcode_in),
		.valid_out(dec_valid),
		.is_push_out(dec_push),
		.is_control_out(dec_ctl),
		.privileged_out(dec_priv),
		.src_out(dec_src),
		.bank_idx_out(dec_bank)
	);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [31:0] gpr [16];
	logic [31:0] next_gpr [16];
	seq_state_t state;
	seq_state_t next_state;
	logic [31:0] pc;
	logic [31:0] next_pc;
	logic busy;
	logic next_busy;
	logic done;
	logic next_done;
	logic exc_valid;
	logic next_exc_valid;
	exc_code_t exc_code;
	exc_code_t next_exc_code;
	logic mem_write;
	logic next_mem_write;
	logic [31:0] mem_addr;
	logic [31:0] next_mem_addr;
	logic [31:0] mem_data;
	logic [31:0] next_mem_data;
	logic [3:0] push_rn;
	logic [3:0] next_push_rn;
	logic [3:0] rd_idx;
	logic [3:0] next_rd_idx;
	logic [31:0] rd_data;
	logic [31:0] next_rd_data;

	logic [3:0] rn;
	logic [3:0] rm;
	logic [31:0] src_val;
	logic [31:0] bank_val;
	logic [31:0] dec_addr;

	assign rn = opcode_in[11:8];
	assign rm = opcode_in[7:4];
	assign dec_addr = gpr[rn] - PUSH_STEP;

	// Bank 0 copy selected when the select bit is 1, bank 1 copy otherwise
	always_comb begin
		if (bank_select_bit_in) begin
			bank_val = banked_gpr_bank0_in[dec_bank*32 +: 32];
		end else begin
			bank_val = banked_gpr_bank1_in[dec_bank*32 +: 32];
		end
	end

	always_comb begin
		case (dec_src)
			SRC_GBR_SEL: src_val = global_base_reg_in;
			SRC_VEC: src_val = vector_base_reg_in;
			SRC_SST: src_val = saved_status_reg_in;
			SRC_SPC_SEL: src_val = saved_pc_reg_in;
			SRC_SSK: src_val = saved_stack_reg_in;
			SRC_DBG: src_val = debug_base_reg_in;
			SRC_BANK: src_val = bank_val;
			SRC_MHI: src_val = mac_high_half_in;
			SRC_MLO: src_val = mac_low_half_in;
			SRC_RET: src_val = procedure_return_reg_in;
			SRC_SUB: src_val = gpr[rn] - gpr[rm];
			default: src_val = 32'h0000_0000;
		endcase
	end

	ctl_store_mem_check u_mem_check (
		.addr_in(mem_addr),
		.tlb_multi_hit_in(tlb_multi_hit_in),
		.tlb_miss_in(tlb_miss_in),
		.tlb_prot_in(tlb_prot_in),
		.page_first_write_in(page_first_write_in),
		.exc_out(mem_exc)
	);

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			next_gpr[i] = gpr[i];
		end
		next_state = state;
		next_pc = pc;
		next_busy = busy;
		next_done = 1'b0;
		next_exc_valid = 1'b0;
		next_exc_code = exc_code;
		next_mem_write = mem_write;
		next_mem_addr = mem_addr;
		next_mem_data = mem_data;
		next_push_rn = push_rn;
		next_rd_idx = rd_idx;
		next_rd_data = rd_data;
		if (gpr_load_in && state == ST_IDLE) begin
			next_gpr[gpr_load_idx_in] = gpr_load_data_in;
		end
		case (state)
			ST_IDLE: begin
				if (issue_in) begin
					if (!dec_valid) begin
						next_exc_valid = 1'b1;
						next_exc_code = EXC_ILLEGAL;
					end else if (in_delay_slot_in && dec_ctl) begin
						next_exc_valid = 1'b1;
						next_exc_code = EXC_SLOT_ILLEGAL;
					end else if (dec_priv && user_mode_in) begin
						next_exc_valid = 1'b1;
						next_exc_code = EXC_ILLEGAL;
					end else if (dec_push) begin
						// Rn updated only once the write is accepted
						next_mem_write = 1'b1;
						next_mem_addr = dec_addr;
						next_mem_data = src_val;
						next_push_rn = rn;
						next_busy = 1'b1;
						next_state = ST_WAIT;
					end else begin
						next_gpr[rn] = src_val;
						next_rd_idx = rn;
						next_rd_data = src_val;
						next_done = 1'b1;
						next_exc_code = EXC_NONE;
						next_pc = pc + PC_STEP;
					end
				end
			end
			ST_WAIT: begin
				if (mem_ack_in) begin
					next_mem_write = 1'b0;
					next_busy = 1'b0;
					next_state = ST_DONE;
					if (mem_exc != EXC_NONE) begin
						next_exc_valid = 1'b1;
						next_exc_code = mem_exc;
					end else begin
						next_gpr[push_rn] = mem_addr;
						next_rd_idx = push_rn;
						next_rd_data = mem_addr;
						next_done = 1'b1;
						next_exc_code = EXC_NONE;
						next_pc = pc + PC_STEP;
					end
				end
			end
			ST_DONE: begin
				next_state = ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			for (int i = 0; i < 16; i++) begin
				gpr[i] <= 32'h0000_0000;
			end
			state <= ST_IDLE;
			pc <= RESET_PC;
			busy <= 1'b0;
			done <= 1'b0;
			exc_valid <= 1'b0;
			exc_code <= EXC_NONE;
			mem_write <= 1'b0;
			mem_addr <= 32'h0000_0000;
			mem_data <= 32'h0000_0000;
			push_rn <= 4'h0;
			rd_idx <= 4'h0;
			rd_data <= 32'h0000_0000;
		end else begin
			for (int i = 0; i < 16; i++) begin
				gpr[i] <= next_gpr[i];
			end
			state <= next_state;
			pc <= next_pc;
			busy <= next_busy;
			done <= next_done;
			exc_valid <= next_exc_valid;
			exc_code <= next_exc_code;
			mem_write <= next_mem_write;
			mem_addr <= next_mem_addr;
			mem_data <= next_mem_data;
			push_rn <= next_push_rn;
			rd_idx <= next_rd_idx;
			rd_data <= next_rd_data;
		end
	end

	assign busy_out = busy;
	assign done_out = done;
	assign exc_valid_out = exc_valid;
	assign exc_code_out = exc_code;
	assign pc_out = pc;
	assign mem_write_out = mem_write;
	assign mem_addr_out = mem_addr;
	assign mem_data_out = mem_data;
	assign rd_idx_out = rd_idx;
	assign rd_data_out = rd_data;

endmodule : control_store_sub_exec

// >>> dv/ctl_store_checker_sva.sv
// Purpose: Port-level checks of the store, push and subtract unit.
// Assumes: One clock, synchronous active-high reset.
// Notes: Bound to the top module.
`timescale 1ns/1ps
module ctl_store_checker
	import ctl_store_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic reset_in,
	input wire logic issue_in,
	input wire logic [15:0] opcode_in,
	input wire logic in_delay_slot_in,
	input wire logic user_mode_in,
	input wire logic bank_select_bit_in,
	input wire logic [31:0] global_base_reg_in,
	input wire logic [255:0] banked_gpr_bank0_in,
	input wire logic [255:0] banked_gpr_bank1_in,
	input wire logic mem_ack_in,
	input wire logic tlb_multi_hit_in,
	input wire logic tlb_miss_in,
	input wire logic tlb_prot_in,
	input wire logic page_first_write_in,
	input wire logic busy_out,
	input wire logic done_out,
	input wire logic exc_valid_out,
	input wire exc_code_t exc_code_out,
	input wire logic [31:0] pc_out,
	input wire logic mem_write_out,
	input wire logic [31:0] mem_addr_out,
	input wire logic [31:0] mem_data_out,
	input wire logic [3:0] rd_idx_out,
	input wire logic [31:0] rd_data_out
);
	logic after_ack, next_after_ack, take, reg_op, push_op, ack_ok;
	logic [31:0] bank_pick;
	assign take = issue_in && !busy_out && !after_ack;
	assign reg_op = take && opcode_in[15:12] == 4'h0 && !in_delay_slot_in;
	assign push_op = take && opcode_in[15:12] == 4'h4 && !in_delay_slot_in;
	assign ack_ok = mem_write_out && mem_ack_in && mem_addr_out[1:0] == 2'h0;
	assign bank_pick = bank_select_bit_in ? banked_gpr_bank0_in[{opcode_in[6:4], 5'h00} +: 32]
		: banked_gpr_bank1_in[{opcode_in[6:4], 5'h00} +: 32];
	always_comb begin
		next_after_ack = reset_in ? 1'b0 : mem_write_out && mem_ack_in;
	end
	always_ff @(posedge sys_clk_in) begin
		after_ack <= next_after_ack;
	end
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (reset_in);
	// ----
	// Assertions
	// ----
	a_gbr_store: assert property (reg_op && opcode_in[7:0] == 8'h12 |=> done_out
		&& rd_idx_out == $past(opcode_in[11:8]) && rd_data_out == $past(global_base_reg_in))
		else $error("gbr store wrong");
	a_bank_store: assert property (reg_op && !user_mode_in && opcode_in[7]
		&& opcode_in[3:0] == 4'h2 |=> done_out && rd_data_out == $past(bank_pick))
		else $error("bank store wrong");
	a_gbr_push: assert property (push_op && opcode_in[7:0] == 8'h13 |=> mem_write_out
		&& busy_out && mem_data_out == $past(global_base_reg_in)) else $error("push data wrong");
	a_priv_trap: assert property (reg_op && user_mode_in && opcode_in[7:0] == 8'h22
		|=> exc_valid_out && !done_out && exc_code_out == EXC_ILLEGAL) else $error("no illegal");
	a_slot_trap: assert property (take && in_delay_slot_in && opcode_in == 16'h0412
		|=> exc_valid_out && exc_code_out == EXC_SLOT_ILLEGAL) else $error("no slot illegal");
	a_push_done: assert property (ack_ok && !tlb_multi_hit_in && !tlb_miss_in
		&& !tlb_prot_in && !page_first_write_in |=> done_out && !busy_out
		&& rd_data_out == $past(mem_addr_out)) else $error("push end wrong");
	a_miss_code: assert property (ack_ok && !tlb_multi_hit_in && tlb_miss_in
		|=> exc_valid_out && exc_code_out == EXC_TLB_MISS) else $error("miss code wrong");
	a_misalign_code: assert property (mem_write_out && mem_ack_in
		&& mem_addr_out[1:0] != 2'h0 |=> exc_valid_out && exc_code_out == EXC_ADDR_ERR)
		else $error("misalign code wrong");
	a_write_hold: assert property (mem_write_out && !mem_ack_in |=> mem_write_out
		&& $stable(mem_addr_out) && $stable(mem_data_out)) else $error("write dropped");
	a_pc_step: assert property (done_out |-> pc_out == $past(pc_out) + PC_STEP)
		else $error("pc step wrong");
	a_pc_hold: assert property (exc_valid_out |-> $stable(pc_out))
		else $error("pc moved on exception");
endmodule : ctl_store_checker

bind control_store_sub_exec ctl_store_checker chk (.*);

// >>> dv/mem_responder.sv
// Purpose: Data memory path answering longword push writes.
// Assumes: Driven on the falling clock edge.
// Notes: Answer delay and reported fault chosen by the bench.
`timescale 1ns/1ps
module mem_responder (
	input wire logic sys_clk_in,
	input wire logic reset_in,
	input wire logic write_req_in,
	input wire logic [2:0] lag_in,
	input wire logic [2:0] fault_sel_in,
	output logic ack_out,
	output logic multi_out,
	output logic miss_out,
	output logic prot_out,
	output logic first_write_out
);
	logic [2:0] waited = 3'h0;
	logic toggle = 1'b0;
	initial begin
		ack_out = 1'b0;
		{multi_out, miss_out, prot_out, first_write_out} = 4'h0;
	end
	// Fault lines churn whenever no answer is given
	always @(negedge sys_clk_in) begin
		toggle <= ~toggle;
		if (!reset_in && write_req_in && !ack_out && waited >= lag_in) begin
			ack_out <= 1'b1;
			{multi_out, miss_out, prot_out, first_write_out} <= 4'h8 >> (fault_sel_in - 3'h1);
			waited <= 3'h0;
		end else begin
			ack_out <= 1'b0;
			{multi_out, miss_out, prot_out, first_write_out} <= {4{toggle}} ^ 4'h5;
			waited <= write_req_in && waited != 3'h7 ? waited + 3'h1 : 3'h0;
		end
	end
endmodule : mem_responder

// >>> dv/control_store_sub_exec_tb.sv
// Purpose: Self-checking bench for the store, push and subtract unit.
// Assumes: Memory answers come from mem_responder.
// Notes: Inputs change on the falling clock edge.
`timescale 1ns/1ps
module control_store_sub_exec_tb
	import ctl_store_pkg::*;
;
	logic sys_clk_in = 1'b0, reset_in = 1'b1, issue_in = 1'b0, in_delay_slot_in = 1'b0;
	logic user_mode_in = 1'b0, bank_select_bit_in = 1'b0, gpr_load_in = 1'b0;
	logic [15:0] opcode_in = 16'h0000;
	logic [3:0] gpr_load_idx_in = 4'h0, rd_idx_out;
	logic [31:0] gpr_load_data_in = 32'h0, srcv [9], exp_pc, pc_out, mem_addr_out, mem_data_out;
	logic [31:0] rd_data_out;
	logic [255:0] bank0, bank1;
	logic [2:0] lag = 3'h0, fault_sel = 3'h0;
	logic mem_ack_in, tlb_multi_hit_in, tlb_miss_in, tlb_prot_in, page_first_write_in;
	logic busy_out, done_out, exc_valid_out, mem_write_out;
	exc_code_t exc_code_out;
	logic [7:0] reg_byte [9] = '{8'h12, 8'h22, 8'h32, 8'h42, 8'h3A, 8'hFA, 8'h0A, 8'h1A, 8'h2A};
	logic [7:0] push_byte [11] = '{8'h13, 8'h23, 8'h33, 8'h43, 8'h32, 8'hF2, 8'h02, 8'h12,
		8'h22, 8'h83, 8'hF3};
	int n_mismatch = 0, tests_run = 0;

	always #2.5 sys_clk_in = ~sys_clk_in;

	control_store_sub_exec uut (.*, .global_base_reg_in(srcv[0]), .vector_base_reg_in(srcv[1]),
		.saved_status_reg_in(srcv[2]), .saved_pc_reg_in(srcv[3]), .saved_stack_reg_in(srcv[4]),
		.debug_base_reg_in(srcv[5]), .mac_high_half_in(srcv[6]), .mac_low_half_in(srcv[7]),
		.procedure_return_reg_in(srcv[8]), .banked_gpr_bank0_in(bank0),
		.banked_gpr_bank1_in(bank1));
	mem_responder mem (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .write_req_in(mem_write_out),
		.lag_in(lag), .fault_sel_in(fault_sel), .ack_out(mem_ack_in), .multi_out(tlb_multi_hit_in),
		.miss_out(tlb_miss_in), .prot_out(tlb_prot_in), .first_write_out(page_first_write_in));

	task automatic check_eq(input string name, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask : check_eq

	task automatic issue(input logic [15:0] op);
		@(negedge sys_clk_in);
		issue_in = 1'b1;
		opcode_in = op;
		@(negedge sys_clk_in);
		issue_in = 1'b0;
	endtask : issue

	task automatic load(input logic [3:0] idx, input logic [31:0] val);
		@(negedge sys_clk_in);
		gpr_load_in = 1'b1;
		gpr_load_idx_in = idx;
		gpr_load_data_in = val;
		@(negedge sys_clk_in);
		gpr_load_in = 1'b0;
	endtask : load

	task automatic finish(input logic [3:0] idx, input logic [31:0] val, input exc_code_t code);
		int k = 0;
		while (done_out !== 1'b1 && exc_valid_out !== 1'b1 && k < 20) begin
			@(negedge sys_clk_in);
			k++;
		end
		if (code == EXC_NONE) begin
			check_eq("done", 32'(done_out), 32'h1);
			check_eq("rd_idx", 32'(rd_idx_out), 32'(idx));
			check_eq("rd_data", rd_data_out, val);
			exp_pc = exp_pc + PC_STEP;
		end else begin
			check_eq("exc_valid", 32'(exc_valid_out), 32'h1);
			check_eq("exc_code", 32'(exc_code_out), 32'(code));
		end
		check_eq("pc", pc_out, exp_pc);
		repeat (2) @(negedge sys_clk_in);
	endtask : finish

	// ----
	// Scenarios
	// ----
	task automatic reg_stores;
		for (int i = 0; i < 9; i++) begin
			issue({8'h03, reg_byte[i]});
			finish(4'h3, srcv[i], EXC_NONE);
		end
		for (int b = 0; b < 2; b++) begin
			bank_select_bit_in = b[0];
			for (int k = 0; k < 8; k++) begin
				issue({8'h07, 1'b1, 3'(k), 4'h2});
				finish(4'h7, (b ? 32'hB0B0_0000 : 32'hC1C1_0000) + 32'(k), EXC_NONE);
			end
		end
	endtask : reg_stores

	task automatic subtract;
		load(4'h1, 32'h0000_0001);
		load(4'h2, 32'h8000_0000);
		issue(16'h3218);
		finish(4'h2, 32'h7FFF_FFFF, EXC_NONE);
		issue(16'h3228);
		finish(4'h2, 32'h0000_0000, EXC_NONE);
	endtask : subtract

	task automatic pushes;
		logic [31:0] base, val;
		for (int i = 0; i < 11; i++) begin
			lag = 3'(i % 3);
			base = 32'h0000_1000 + 32'(i * 16);
			val = i < 9 ? srcv[i] : 32'hB0B0_0000 + (i == 10 ? 32'h7 : 32'h0);
			load(4'h5, base);
			issue({8'h45, push_byte[i]});
			check_eq("mem_write", 32'(mem_write_out), 32'h1);
			check_eq("mem_addr", mem_addr_out, base - PUSH_STEP);
			check_eq("mem_data", mem_data_out, val);
			finish(4'h5, base - PUSH_STEP, EXC_NONE);
		end
		for (int f = 1; f < 6; f++) begin
			fault_sel = f < 5 ? 3'(f) : 3'h0;
			load(4'h6, f < 5 ? 32'h0000_2000 : 32'h0000_2002);
			issue(16'h4613);
			finish(4'h6, 32'h0, exc_code_t'(f + 2));
		end
		fault_sel = 3'h0;
	endtask : pushes

	task automatic privilege;
		user_mode_in = 1'b1;
		issue(16'h0422);
		finish(4'h4, 32'h0, EXC_ILLEGAL);
		issue(16'h0412);
		finish(4'h4, srcv[0], EXC_NONE);
		issue(16'h4483);
		finish(4'h4, 32'h0, EXC_ILLEGAL);
		user_mode_in = 1'b0;
		in_delay_slot_in = 1'b1;
		issue(16'h0412);
		finish(4'h4, 32'h0, EXC_SLOT_ILLEGAL);
		in_delay_slot_in = 1'b0;
	endtask : privilege

	task automatic test_done;
		$display("checks %0d, mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : test_done

	initial begin
		for (int i = 0; i < 9; i++) srcv[i] = 32'h5A5A_0000 + 32'(i);
		for (int k = 0; k < 8; k++) begin
			bank0[k * 32 +: 32] = 32'hB0B0_0000 + 32'(k);
			bank1[k * 32 +: 32] = 32'hC1C1_0000 + 32'(k);
		end
		exp_pc = RESET_PC;
		repeat (10) @(negedge sys_clk_in);
		reset_in = 1'b0;
		check_eq("pc", pc_out, RESET_PC);
		reg_stores();
		subtract();
		bank_select_bit_in = 1'b1;
		pushes();
		privilege();
		test_done();
	end

	// Whole run needs about 270 cycles; allow about fifteen times that
	initial begin
		#20000;
		n_mismatch++;
		test_done();
	end
endmodule : control_store_sub_exec_tb
